// *** design/pcl_pkg.sv ***
// Package: constants and carrier types for the parallel configuration loader
package pcl_pkg;

  // Core clock rate and timing figures
  localparam int unsigned CORE_CLK_MHZ    = 25;
  localparam int unsigned STATUS_HOLD_NS  = 200;   // Status held low after reset
  localparam int unsigned CD2CU_NS        = 300;   // Done to user clock delay
  localparam int unsigned STATUS_HOLD_CYC =
    (STATUS_HOLD_NS * CORE_CLK_MHZ + 999) / 1000;  // Least time, rounded up
  localparam int unsigned CD2CU_CYC       =
    (CD2CU_NS * CORE_CLK_MHZ + 999) / 1000;        // Least time, rounded up

  // Initialisation length and stream size defaults
  localparam int unsigned INIT_CYCLES     = 3192;
  localparam int unsigned STREAM_BYTES    = 1024;
  localparam int unsigned POST_FALL_EDGES = 2;

  // Counter widths
  localparam int unsigned TMR_W = 12;
  localparam int unsigned CNT_W = 16;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_HOLD  = 3'h0,
    ST_LOAD  = 3'h1,
    ST_DELAY = 3'h2,
    ST_INIT  = 3'h3,
    ST_USER  = 3'h4
  } pcl_state_t;

  // Byte delivered to the configuration memory, link domain
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pcl_byte_t;

  // Open-drain pin drive
  typedef struct packed {
    logic o;
    logic oe;
  } pcl_od_t;

endpackage

// *** design/pcl_loader.sv ***
// Parallel configuration slave port with load and initialisation sequencing
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Releasing status line means ready; configuration stage starts then.
// - Each byte is captured on the rising edge of the byte clock.
// - Parallel mode raises load-complete one byte before the stream ends.
// - User init clock never affects loading; enabled after a fixed delay.
// - After the delay, count 3,192 init clock cycles.
// - Init-complete output is released high when initialisation finishes.
// - User mode removes the weak pull-ups from user pins.
// - Chain master holds chain-enable output high during its own cycle.
// - After its cycle the master drives chain-enable low for the slaves.
// - Unused chain-enable output may serve as a plain user pin.
// - Done and status are open-drain outputs only; each device enters user mode at the end of its own count.
// - A configured chain device drives its chain-enable output low.
module pcl_loader #(
  parameter int unsigned STREAM_LEN = pcl_pkg::STREAM_BYTES,
  parameter int unsigned INIT_LEN   = pcl_pkg::INIT_CYCLES
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             config_byte_clock_i,
  input  wire logic [7:0]       config_data_i,
  input  wire logic             chip_config_enable_low_i,
  input  wire logic             reconfig_request_low_i,
  input  wire logic             optional_user_init_clock_i,
  input  wire logic             use_user_init_clock_i,
  input  wire logic             chain_pin_as_user_io_i,
  input  wire logic             user_chain_pin_i,
  input  wire logic             user_chain_pin_oe_i,
  output pcl_pkg::pcl_od_t      config_ready_status_low_o,
  output pcl_pkg::pcl_od_t      init_done_o,
  output logic                  load_complete_flag_o,
  output pcl_pkg::pcl_byte_t    config_byte_o,
  output logic                  chain_enable_out_low_o,
  output logic                  chain_enable_out_oe_o,
  output logic                  weak_pullup_en_o,
  output logic                  user_mode_o
);
  import pcl_pkg::*;

  // Refuse lengths that the counters cannot hold
  if (STREAM_LEN < 2 || STREAM_LEN >= (1 << CNT_W)) begin : g_bad_stream
    $error("STREAM_LEN out of range");
  end
  if (INIT_LEN < 1 || INIT_LEN >= (1 << TMR_W)) begin : g_bad_init
    $error("INIT_LEN out of range");
  end

  localparam logic [CNT_W-1:0] LAST_IDX  = CNT_W'(STREAM_LEN - 1);
  localparam logic [CNT_W-1:0] EARLY_IDX = CNT_W'(STREAM_LEN - 2);
  localparam logic [TMR_W-1:0] HOLD_END  = TMR_W'(STATUS_HOLD_CYC - 1);
  localparam logic [TMR_W-1:0] DLY_END   = TMR_W'(CD2CU_CYC - 1);
  localparam logic [TMR_W-1:0] INIT_END  = TMR_W'(INIT_LEN - 1);
  localparam logic [1:0]       FALL_END  = 2'(POST_FALL_EDGES);
  localparam int               DLY_CHK_CYC = int'(CD2CU_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: pin synchronisers
  logic reconf_m_r, reconf_s_r;
  logic uclk_m_r, uclk_s_r, uclk_d_r;
  logic go_m_r, go_s_r;
  logic init_go_r;   // Link-domain level, read here only through go_m_r

  // Two flops per asynchronous input, plus a third on the user clock for edge detection; the first stage is read only by the second
  always_ff @(posedge core_clk_i) begin
    reconf_m_r <= reconfig_request_low_i;
    reconf_s_r <= reconf_m_r;
    uclk_m_r   <= optional_user_init_clock_i;
    uclk_s_r   <= uclk_m_r;
    uclk_d_r   <= uclk_s_r;
    go_m_r     <= init_go_r;
    go_s_r     <= go_m_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: sequencer
  pcl_state_t       state_r, state_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;
  logic             restart_w;
  logic             init_tick_w;
  logic             tmr_done_w;

  // A low request restarts the whole sequence from the hold state
  assign restart_w   = ~reconf_s_r;
  // Init counting uses the user clock when chosen, else the core clock
  assign init_tick_w = use_user_init_clock_i ? (uclk_s_r & ~uclk_d_r) : 1'b1;
  assign tmr_done_w  = (state_r == ST_HOLD)  ? (tmr_r == HOLD_END) :
                       (state_r == ST_DELAY) ? (tmr_r == DLY_END)  :
                       (state_r == ST_INIT)  ? (tmr_r == INIT_END) : 1'b0;

  // Next state and timer
  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r;
    unique case (state_r)
      ST_HOLD: begin
        tmr_nxt = tmr_r + TMR_W'(1);
        if (tmr_done_w) begin
          state_nxt = ST_LOAD;
          tmr_nxt   = '0;
        end
      end
      ST_LOAD: begin
        if (go_s_r) begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        tmr_nxt = tmr_r + TMR_W'(1);
        if (tmr_done_w) begin
          state_nxt = ST_INIT;
          tmr_nxt   = '0;
        end
      end
      ST_INIT: begin
        if (init_tick_w) begin
          tmr_nxt = tmr_r + TMR_W'(1);
          if (tmr_done_w) begin
            state_nxt = ST_USER;
          end
        end
      end
      ST_USER: begin
        state_nxt = ST_USER;
      end
      default: begin
        state_nxt = ST_HOLD;
        tmr_nxt   = '0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || restart_w) begin
      state_r <= ST_HOLD;
      tmr_r   <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  // Registered pin drives
  logic open_r, user_r;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || restart_w) begin
      open_r <= 1'b0;
      user_r <= 1'b0;
    end else begin
      open_r <= (state_nxt != ST_HOLD);
      user_r <= (state_nxt == ST_USER);
    end
  end

  assign config_ready_status_low_o = '{o: 1'b0, oe: ~open_r};
  assign init_done_o               = '{o: 1'b0, oe: ~user_r};
  assign weak_pullup_en_o          = ~user_r;
  assign user_mode_o               = user_r;

  // High through own load, low once configured
  // Chain enable low once done; the pin may instead serve the user
  assign chain_enable_out_low_o = chain_pin_as_user_io_i ? user_chain_pin_i :
                                  ~user_r;
  // Pin given to the user design
  assign chain_enable_out_oe_o  = chain_pin_as_user_io_i ? user_chain_pin_oe_i :
                                  1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: reset taken at once while status is low, released after two
  // byte clocks, so the link state clears although the host clock stands still
  logic open_m_r, open_s_r;
  always_ff @(posedge config_byte_clock_i or negedge open_r) begin
    if (!open_r) begin
      open_m_r <= 1'b0;
      open_s_r <= 1'b0;
    end else begin
      open_m_r <= 1'b1;
      open_s_r <= open_m_r;
    end
  end

  // Chip enable pin, two flops; a change takes effect two byte clocks late
  logic ce_m_r, ce_s_r;
  always_ff @(posedge config_byte_clock_i) begin
    ce_m_r <= chip_config_enable_low_i;
    ce_s_r <= ce_m_r;
  end

  // Byte capture, gated by the status release and the chip enable.
  // The byte clock may stop between frames; nothing here needs it to run.
  logic [CNT_W-1:0] bcnt_r;
  logic             load_r, full_r;
  pcl_byte_t        byte_r;
  logic             take_w;

  assign take_w = open_s_r & ~ce_s_r & ~full_r;

  always_ff @(posedge config_byte_clock_i or negedge open_s_r) begin
    if (!open_s_r) begin
      bcnt_r <= '0;
      load_r <= 1'b0;
      full_r <= 1'b0;
      byte_r <= '0;
    end else begin
      byte_r <= '{valid: take_w, data: config_data_i};
      if (take_w) begin
        bcnt_r <= bcnt_r + CNT_W'(1);
        full_r <= (bcnt_r == LAST_IDX);
        if (bcnt_r == EARLY_IDX) begin
          load_r <= 1'b1;
        end
      end
    end
  end

  assign config_byte_o        = byte_r;
  assign load_complete_flag_o = load_r;

  // Count falling edges after load-complete; result crosses as a level
  logic [1:0] fall_r;
  always_ff @(negedge config_byte_clock_i or negedge open_s_r) begin
    if (!open_s_r) begin
      fall_r    <= '0;
      init_go_r <= 1'b0;
    end else if (load_r && fall_r != FALL_END) begin
      fall_r    <= fall_r + 2'h1;
      init_go_r <= (fall_r == FALL_END - 2'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Status release check
  chk_status_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(state_r == ST_LOAD) |-> !config_ready_status_low_o.oe)
    else $error("status not released on entry to load");

  chk_early_done: assert property (@(posedge config_byte_clock_i) disable iff (!open_s_r)
    $rose(load_r) |-> (bcnt_r == LAST_IDX) && !full_r)
    else $error("load-complete not one byte early");

  chk_capture_stop: assert property (@(posedge config_byte_clock_i) disable iff (!open_s_r)
    full_r |=> !byte_r.valid)
    else $error("byte taken after stream end");

  chk_two_falls: assert property (@(negedge config_byte_clock_i) disable iff (!open_s_r)
    $rose(init_go_r) |-> fall_r == FALL_END && load_r)
    else $error("init start without two falling edges");

  chk_delay_len: assert property (@(posedge core_clk_i) disable iff (!rst_n_i || restart_w)
    $rose(state_r == ST_DELAY) |-> ##DLY_CHK_CYC state_r == ST_INIT)
    else $error("enable delay wrong length");

  chk_init_end: assert property (@(posedge core_clk_i) disable iff (!rst_n_i || restart_w)
    $rose(state_r == ST_USER) |-> $past(tmr_r) == INIT_END)
    else $error("user mode before init count ended");

  chk_done_release: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i || restart_w)
    $rose(state_r == ST_USER) |-> !init_done_o.oe && !weak_pullup_en_o)
    else $error("init-complete or pull-ups wrong in user mode");

  chk_chain_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !chain_pin_as_user_io_i |-> chain_enable_out_low_o == (state_r != ST_USER))
    else $error("chain enable not following completion");

endmodule
`default_nettype wire

// *** verification/pcl_host_model.sv ***
// Host controller model that feeds configuration bytes and the byte clock
`timescale 1ns/100ps
`default_nettype none
module pcl_host_model (
  input  wire logic       status_hi_i,
  input  wire logic       go_i,
  input  wire logic       load_done_i,
  input  wire logic [7:0] rnd_i,
  output logic            byte_clk_o,
  output logic [7:0]      data_o,
  output logic            sending_o
);
  // One link clock period; the clock stands low between frames
  task automatic pulse;
    #40 byte_clk_o = 1'b1;
    #40 byte_clk_o = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer; data changes only while the clock is low, for full setup
  initial begin
    byte_clk_o = 1'b0;
    data_o = 8'h00;
    sending_o = 1'b0;
    forever begin
      wait (go_i && status_hi_i);
      #13;
      // Two sync edges that carry no byte
      repeat (2) begin
        data_o = ~data_o;
        pulse;
      end
      sending_o = 1'b1;
      // one image; bytes until load-complete, last gives second fall
      while (load_done_i !== 1'b1) begin
        data_o = rnd_i;
        pulse;
      end
      data_o = rnd_i;
      pulse;
      sending_o = 1'b0;
      // Clock parked low, data held between frames
      data_o = ~data_o; // Released bus never shows the stale byte
      wait (!go_i);
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Testbench: host model drives the loader, a queue model checks bytes and timing
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pcl_pkg::*;
  localparam int SL = 8;
  localparam int IL = 16;
  logic       clk, rst_n, ce_low, req_low, uclk, use_u, as_io, upin, upin_oe, go;
  logic [7:0] rnd;
  logic       ce_d1, ce_d2;
  wire logic  bclk, sending, lc, ch_low, ch_oe, pu, um;
  wire logic [7:0] data;
  pcl_od_t    st, idn;
  pcl_byte_t  cb;
  int         n_fail, comparisons, cyc, n_taken, seed;
  logic [7:0] exp_q[$];

  pcl_loader #(.STREAM_LEN(SL), .INIT_LEN(IL)) u_pcl_loader (
    .core_clk_i(clk), .rst_n_i(rst_n), .config_byte_clock_i(bclk), .config_data_i(data),
    .chip_config_enable_low_i(ce_low), .reconfig_request_low_i(req_low),
    .optional_user_init_clock_i(uclk), .use_user_init_clock_i(use_u),
    .chain_pin_as_user_io_i(as_io), .user_chain_pin_i(upin), .user_chain_pin_oe_i(upin_oe),
    .config_ready_status_low_o(st), .init_done_o(idn), .load_complete_flag_o(lc),
    .config_byte_o(cb), .chain_enable_out_low_o(ch_low), .chain_enable_out_oe_o(ch_oe),
    .weak_pullup_en_o(pu), .user_mode_o(um));
  pcl_host_model u_pcl_host_model (.status_hi_i(st.oe === 1'b0), .go_i(go), .load_done_i(lc),
    .rnd_i(rnd), .byte_clk_o(bclk), .data_o(data), .sending_o(sending));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // User init clock toggles throughout, loading must ignore it; hang guard
  always @(posedge clk) begin
    uclk <= ~uclk;
    rnd <= 8'($random(seed));
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      test_done;
    end
  end
  // Expected bytes: chip enable reaches the capture two byte clocks late
  always @(posedge bclk) begin
    ce_d1 <= ce_low;
    ce_d2 <= ce_d1;
    if (sending && ce_d2 === 1'b0) exp_q.push_back(data);
  end
  always @(negedge bclk) begin
    if (cb.valid === 1'b1) begin
      n_taken++;
      chk(cb.data, exp_q.size() ? exp_q.pop_front() : ~cb.data);
      if (n_taken == SL - 1) chk(lc, 1'b1);
      if (n_taken == SL - 2) chk(lc, 1'b0);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // One full load and initialisation; dly keeps the chip disabled a while
  task automatic run(input logic uu, input logic io, input int dly);
    int n;
    int lo;
    @(posedge clk);
    {use_u, as_io, ce_low, req_low, n_taken} <= {uu, io, 2'b10, 32'd0};
    {upin, upin_oe} <= rnd[1:0];
    repeat (4) @(posedge clk);
    req_low <= 1'b1;
    go <= 1'b1;
    n = 0;
    while (st.oe !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(n >= STATUS_HOLD_CYC && n <= STATUS_HOLD_CYC + 4, 1'b1);
    chk({ch_low, pu, um, idn.oe}, {io ? upin : 1'b1, 3'b101});
    repeat (dly) @(posedge clk);
    ce_low <= 1'b0;
    while (lc !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    lo = CD2CU_CYC + IL * (uu ? 2 : 1);
    while (um !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(n >= lo && n <= lo + 20, 1'b1);
    chk({idn.oe, pu}, 2'b00);
    chk({ch_low, ch_oe}, io ? {upin, upin_oe} : 2'b01);
    chk(exp_q.size(), 0);
    @(posedge clk);
    go <= 1'b0;
    $display("test done: user clock %0d chain pin user %0d", uu, io);
  endtask

  initial begin
    {rst_n, ce_low, req_low, uclk, use_u, as_io, upin, upin_oe, go} = 9'b011000000;
    {rnd, cyc, n_fail, comparisons, n_taken, seed} = {8'h00, 128'd0, 32'd26};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    run(1'b0, 1'b0, 1);
    run(1'b1, 1'b1, 10);
    test_done;
  end
endmodule
`default_nettype wire
